// ==== common/mcim_pkg.sv ====
// package for the memory channel interleave map: constants and carrier structs
package mcim_pkg;
   localparam int NUM_CU        = 12;   // requesting compute units
   localparam int NUM_CH        = 12;   // channels in the largest mode
   localparam int CH_W          = 4;
   localparam int CU_W          = 4;
   localparam int ADDR_W        = 32;
   localparam int OFFS_MSB      = 7;    // bits 7:0 are the intra-channel offset
   localparam int CH_LSB        = 8;    // channel field starts here
   localparam int PIPE_W        = 3;    // virtual pipe is bits 10:8
   localparam int CH8_W         = 3;    // eight-channel select width
   localparam int CH4_W         = 2;    // four-channel select width
   localparam int QUAD_SIZE     = 3;    // channels per quadrant
   localparam int L2_BYTES      = 65536;
   localparam int L2_LINE_BYTES = 64;
   localparam int L2_LINES      = L2_BYTES / L2_LINE_BYTES;
   localparam int WAVE_ITEMS    = 64;
   localparam int INTERLEAVE_B  = 256;
   localparam int BANK_W        = 3;    // bank field width above the channel field
   localparam int GRP_W         = 16;   // work-group index width
   localparam logic [CH_W-1:0]   CH_RST  = 4'h0;
   localparam logic [GRP_W-1:0]  GRP_RST = 16'h0000;

   typedef enum logic [1:0] {MCIM_MODE_12, MCIM_MODE_8, MCIM_MODE_4} mcim_mode_e;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [5:0]        wave_id;
   } mcim_req_s;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [CU_W-1:0]   src_cu;
      logic [5:0]        wave_id;
   } mcim_chreq_s;
endpackage : mcim_pkg

// ==== design/mcim_router.sv ====
// memory channel interleave map: address decode, crossbar steering and launch order
`timescale 1ns/1ps
// Functional notes
// - twelve channels, crossbar steers by address
// - each channel has 64 kB L2, 64-byte lines
// - bits 7:0 offset, channel from bit 8
// - twelve-channel mode uses bits 10:8 as pipe
// - four quadrants of three; pipe top bits
// - row-bank mod 3 ==1 picks 1, else 2*pipe0
// - eight-channel mode uses bits 10:8
// - four-channel mode uses bits 9:8
// - linear addresses change channel every 256 bytes; in twelve-channel rows with residue 1, every 512
// - same channel and bank requests serialize
// - launch index is x plus y times nx
// - free units take next group; retire in order
// - one wavefront issue per unit per cycle
// - at most twelve unit accesses per cycle
module mcim_router (
   input  wire logic                                ref_clk_in,
   input  wire logic                                rst_in,
   input  wire mcim_pkg::mcim_mode_e                mode_in,
   input  wire mcim_pkg::mcim_req_s [11:0]          cu_req_in,
   output logic                     [11:0]          cu_ready_out,
   output mcim_pkg::mcim_chreq_s    [11:0]          ch_req_out,
   input  wire logic                [11:0]          ch_ready_in,
   input  wire logic                                launch_start_in,
   input  wire logic [mcim_pkg::GRP_W-1:0]          num_groups_x_in,
   input  wire logic [mcim_pkg::GRP_W-1:0]          num_groups_y_in,
   input  wire logic                [11:0]          cu_done_in,
   output logic                                     launch_valid_out,
   output logic [mcim_pkg::CU_W-1:0]                launch_cu_out,
   output logic [mcim_pkg::GRP_W-1:0]               launch_group_x_out,
   output logic [mcim_pkg::GRP_W-1:0]               launch_group_y_out,
   output logic [mcim_pkg::GRP_W-1:0]               workgroup_launch_index_out,
   output logic [mcim_pkg::GRP_W-1:0]               retire_index_out,
   output logic                                     launch_busy_out
);
   localparam int NC = mcim_pkg::NUM_CU;

   // per-channel second-level cache geometry; the cache itself lives behind
   // each slot, so only its size is carried here for whatever hangs off them
   localparam int L2_BYTES_CH = mcim_pkg::L2_BYTES;
   localparam int L2_LINE_B   = mcim_pkg::L2_LINE_BYTES;
   localparam int L2_LINES_CH = mcim_pkg::L2_LINES;

   typedef struct packed {
      mcim_pkg::mcim_chreq_s [11:0]          ch;
      logic [mcim_pkg::GRP_W-1:0]            gx;
      logic [mcim_pkg::GRP_W-1:0]            gy;
      logic [mcim_pkg::GRP_W-1:0]            lidx;
      logic [mcim_pkg::GRP_W-1:0]            ridx;
      logic [mcim_pkg::GRP_W-1:0]            total;
      logic                                  busy;
      logic                                  lv;
      logic [mcim_pkg::CU_W-1:0]             lcu;
      logic [mcim_pkg::GRP_W-1:0]            lgx;
      logic [mcim_pkg::GRP_W-1:0]            lgy;
      logic [mcim_pkg::GRP_W-1:0]            lout;
      logic [11:0]                           occ;
      logic [11:0][mcim_pkg::GRP_W-1:0]      grp;   // launch index held by each unit
      logic [11:0]                           done;  // finished but not yet retired
   } mcim_state_s;

   mcim_state_s st_ff;
   mcim_state_s nxt_st;

   // channel select for one address; the residue is recomputed every cycle
   function automatic logic [mcim_pkg::CH_W-1:0] mcim_chan(
      input logic [mcim_pkg::ADDR_W-1:0] a,
      input mcim_pkg::mcim_mode_e        m);
      logic [mcim_pkg::PIPE_W-1:0] pipe;
      logic [1:0]                  quad;
      logic [1:0]                  sub;
      logic [1:0]                  res;
      pipe = a[mcim_pkg::CH_LSB +: mcim_pkg::PIPE_W];
      quad = pipe[2:1];
      // the residue takes every bit above the pipe field, a wide divide by three
      // in the grant path: the price of an exact twelve-way mapping
      res  = 2'((a >> (mcim_pkg::CH_LSB + mcim_pkg::PIPE_W)) % mcim_pkg::QUAD_SIZE);
      sub  = (res == 2'h1) ? 2'h1 : {pipe[0], 1'b0};
      // twelve-channel default: quadrant base plus place in the quadrant
      case (m)
         mcim_pkg::MCIM_MODE_8: mcim_chan = 4'(a[mcim_pkg::CH_LSB +: mcim_pkg::CH8_W]);
         mcim_pkg::MCIM_MODE_4: mcim_chan = 4'(a[mcim_pkg::CH_LSB +: mcim_pkg::CH4_W]);
         default:               mcim_chan = 4'(quad * 3) + 4'(sub);
      endcase
   endfunction : mcim_chan

   // no bank decode of its own: a bank lies inside one channel, so holding back
   // every same-channel loser also serialises same-bank requests
   logic [11:0][mcim_pkg::CH_W-1:0]   req_ch;
   logic [11:0]                       grant;

   // per-unit decode; one request per unit per cycle, a unit carries one wavefront
   genvar gi;
   generate
      for (gi = 0; gi < NC; gi++) begin : g_dec
         assign req_ch[gi]   = mcim_chan(cu_req_in[gi].addr, mode_in);
      end
   endgenerate

   // fixed-priority grant: lowest unit wins a channel, losers with the same
   // channel (hence same bank or not) retry next cycle; a stalled output slot
   // holds its request so nothing is dropped
   always_comb begin
      logic [11:0] taken;
      taken = '0;
      grant = '0;
      for (int c = 0; c < NC; c++) begin
         taken[c] = st_ff.ch[c].valid && !ch_ready_in[c];
      end
      // lowest-numbered unit first, at most one grant per channel
      for (int u = 0; u < NC; u++) begin
         if (cu_req_in[u].valid && !taken[req_ch[u]]) begin
            grant[u]          = 1'b1;
            taken[req_ch[u]]  = 1'b1;
         end
      end
   end

   // grant is the ready: combinational, so a unit sees refusal in the same cycle
   assign cu_ready_out = grant;

   // next-state logic for crossbar slots and work-group launcher
   always_comb begin
      logic [mcim_pkg::CU_W-1:0]  fcu;
      logic                       ffree;
      logic                       more;
      nxt_st = st_ff;
      fcu    = '0;
      ffree  = 1'b0;
      more   = 1'b0;
      // a slot that its channel takes this cycle empties, and may refill below
      for (int c = 0; c < NC; c++) begin
         if (st_ff.ch[c].valid && ch_ready_in[c]) begin
            nxt_st.ch[c].valid = 1'b0;
         end
      end
      for (int u = 0; u < NC; u++) begin
         if (grant[u]) begin
            nxt_st.ch[req_ch[u]].valid   = 1'b1;
            nxt_st.ch[req_ch[u]].write   = cu_req_in[u].write;
            nxt_st.ch[req_ch[u]].addr    = cu_req_in[u].addr;
            nxt_st.ch[req_ch[u]].src_cu  = 4'(u);
            nxt_st.ch[req_ch[u]].wave_id = cu_req_in[u].wave_id;
         end
      end
      // completion marks are sticky until the marked unit's group retires as the oldest
      // a done pulse from a unit that holds no group is dropped
      for (int u = 0; u < NC; u++) begin
         if (cu_done_in[u] && st_ff.occ[u]) begin
            nxt_st.done[u] = 1'b1;
         end
      end
      // retire only the oldest group, so the live set stays contiguous
      for (int u = 0; u < NC; u++) begin
         if (st_ff.occ[u] && st_ff.done[u] && st_ff.grp[u] == st_ff.ridx) begin
            nxt_st.occ[u]  = 1'b0;
            nxt_st.done[u] = 1'b0;
            nxt_st.ridx    = st_ff.ridx + 16'h0001;
         end
      end
      for (int u = NC - 1; u >= 0; u--) begin
         if (!st_ff.occ[u]) begin
            ffree = 1'b1;
            fcu   = 4'(u);
         end
      end
      // at most one launch per cycle, always to the lowest free unit
      nxt_st.lv = 1'b0;
      more = st_ff.lidx != st_ff.total;
      if (launch_start_in && !st_ff.busy) begin
         nxt_st.busy  = 1'b1;
         nxt_st.gx    = mcim_pkg::GRP_RST;
         nxt_st.gy    = mcim_pkg::GRP_RST;
         nxt_st.lidx  = mcim_pkg::GRP_RST;
         nxt_st.ridx  = mcim_pkg::GRP_RST;
         nxt_st.total = 16'(num_groups_x_in * num_groups_y_in);
      end else if (st_ff.busy && more && ffree) begin
         nxt_st.lv        = 1'b1;
         nxt_st.lcu       = fcu;
         nxt_st.lgx       = st_ff.gx;
         nxt_st.lgy       = st_ff.gy;
         // index rebuilt from x and y, not copied from the launch counter
         nxt_st.lout      = 16'(st_ff.gx + st_ff.gy * num_groups_x_in);
         nxt_st.occ[fcu]  = 1'b1;
         nxt_st.grp[fcu]  = st_ff.lidx;
         nxt_st.lidx      = st_ff.lidx + 16'h0001;
         // x runs fastest; at the end of a row x wraps and y steps
         if (st_ff.gx + 16'h0001 == num_groups_x_in) begin
            nxt_st.gx = mcim_pkg::GRP_RST;
            nxt_st.gy = st_ff.gy + 16'h0001;
         end else begin
            nxt_st.gx = st_ff.gx + 16'h0001;
         end
      end else if (st_ff.busy && !more && st_ff.ridx == st_ff.total) begin
         // busy drops only once the last group has retired
         nxt_st.busy = 1'b0;
      end
   end

   // state register; a synchronous reset empties every slot and drops the grid,
   // so a grid cut by reset must be started again
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // every output but cu_ready_out is a plain copy of the state register
   assign ch_req_out                 = st_ff.ch;
   assign launch_valid_out           = st_ff.lv;
   assign launch_cu_out              = st_ff.lcu;
   assign launch_group_x_out         = st_ff.lgx;
   assign launch_group_y_out         = st_ff.lgy;
   assign workgroup_launch_index_out = st_ff.lout;
   assign retire_index_out           = st_ff.ridx;
   assign launch_busy_out            = st_ff.busy;
endmodule : mcim_router

// ==== tb/mcim_ch_model.sv ====
// memory channel side model: takes slots promptly, slowly or not at all
`timescale 1ns/1ps
module mcim_ch_model (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   input  wire logic [1:0]  pace_in,
   output logic      [11:0] ch_ready_out
);
   logic tog_ff;
   // slow pace only accepts on every other cycle
   always_ff @(posedge ref_clk_in) tog_ff <= rst_in ? 1'b0 : ~tog_ff;
   assign ch_ready_out = (pace_in == 2'h0) ? 12'hfff : (pace_in == 2'h1) ? 12'h000 : {12{tog_ff}};
endmodule : mcim_ch_model

// ==== tb/mcim_router_monitor.sv ====
// assertion checker watching the router ports
`timescale 1ns/1ps
module mcim_router_monitor (
   input wire logic                         ref_clk_in,
   input wire logic                         rst_in,
   input wire mcim_pkg::mcim_mode_e         mode_in,
   input wire mcim_pkg::mcim_req_s   [11:0] cu_req_in,
   input wire logic                  [11:0] cu_ready_out,
   input wire mcim_pkg::mcim_chreq_s [11:0] ch_req_out,
   input wire logic                  [11:0] ch_ready_in,
   input wire logic                         launch_start_in,
   input wire logic                  [15:0] num_groups_x_in,
   input wire logic                  [15:0] num_groups_y_in,
   input wire logic                         launch_valid_out,
   input wire logic                  [15:0] workgroup_launch_index_out,
   input wire logic                  [15:0] retire_index_out,
   input wire logic                         launch_busy_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   logic [15:0] cnt_ff;
   logic        bad_map;
   // own channel decode, kept apart from the design's
   function automatic logic [3:0] chan(logic [31:0] a, mcim_pkg::mcim_mode_e m);
      logic [3:0] sub;
      sub = ((a >> 11) % 32'h3 == 32'h1) ? 4'h1 : {2'h0, a[8], 1'b0};
      if (m == mcim_pkg::MCIM_MODE_8) return {1'b0, a[10:8]};
      if (m == mcim_pkg::MCIM_MODE_4) return {2'h0, a[9:8]};
      return {2'h0, a[10:9]} * 4'h3 + sub;
   endfunction : chan
   // launches since the last accepted start; each new grid restarts the count from zero
   always_ff @(posedge ref_clk_in)
      if (rst_in || (launch_start_in && !launch_busy_out)) cnt_ff <= 16'h0;
      else if (launch_valid_out) cnt_ff <= cnt_ff + 16'h1;
   // a filled slot must hold an address decoding to its own channel
   always_comb begin
      bad_map = 1'b0;
      for (int c = 0; c < 12; c++)
         if (ch_req_out[c].valid && chan(ch_req_out[c].addr, mode_in) != 4'(c)) bad_map = 1'b1;
   end
   a_slot_map: assert property (!bad_map)
      else $error("slot on wrong channel");
   a_arb_prio: assert property (cu_req_in[0].valid && cu_req_in[1].valid &&
      chan(cu_req_in[0].addr, mode_in) == chan(cu_req_in[1].addr, mode_in) |-> !cu_ready_out[1])
      else $error("same channel granted twice");
   a_slot_hold: assert property (ch_req_out[0].valid && !ch_ready_in[0] |=> $stable(ch_req_out[0]))
      else $error("stalled slot changed");
   a_start_busy: assert property (launch_start_in && !launch_busy_out |=> launch_busy_out)
      else $error("start did not set busy");
   a_first_launch: assert property (launch_start_in && !launch_busy_out && num_groups_x_in != 16'h0 &&
      num_groups_y_in != 16'h0 |-> ##2 launch_valid_out) else $error("first launch late");
   a_launch_idx: assert property (launch_valid_out |-> workgroup_launch_index_out == cnt_ff)
      else $error("launch out of order");
   a_retire_step: assert property (!$stable(retire_index_out) && !$past(launch_start_in) |->
      retire_index_out == $past(retire_index_out) + 16'h1)
      else $error("retire jumped");
   a_retire_behind: assert property (retire_index_out <= cnt_ff)
      else $error("retire ahead of launch");
   c_launch: cover property (launch_valid_out);
   c_stall: cover property (ch_req_out[0].valid && !ch_ready_in[0]);
   c_retire: cover property (retire_index_out != 16'h0);
endmodule : mcim_router_monitor
bind mcim_router mcim_router_monitor u_mon (.ref_clk_in, .rst_in, .mode_in, .cu_req_in, .cu_ready_out,
   .ch_req_out, .ch_ready_in, .launch_start_in, .num_groups_x_in, .num_groups_y_in, .launch_valid_out,
   .workgroup_launch_index_out, .retire_index_out, .launch_busy_out);

// ==== tb/tb_mcim_router.sv ====
// self-checking bench for the interleave map router
`timescale 1ns/1ps
module tb_mcim_router;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, launch_start_in = 1'b0, launch_valid_out, launch_busy_out;
   mcim_pkg::mcim_mode_e mode_in = mcim_pkg::MCIM_MODE_12;
   mcim_pkg::mcim_req_s [11:0] cu_req_in = '0;
   mcim_pkg::mcim_chreq_s [11:0] ch_req_out;
   logic [11:0] cu_ready_out, ch_ready_in, cu_done_in = 12'h000;
   logic [1:0] pace = 2'h0;
   logic [3:0] launch_cu_out;
   logic [15:0] num_groups_x_in = 16'h0007, num_groups_y_in = 16'h0002, launch_group_x_out, launch_group_y_out;
   logic [15:0] workgroup_launch_index_out, retire_index_out;
   int err_count = 0, checked = 0, cycles = 0;
   // twelve-channel addresses, entry n decodes to channel n
   logic [31:0] adr [12] = '{32'h000, 32'h800, 32'h100, 32'h200, 32'ha00, 32'h300,
                             32'h400, 32'hc00, 32'h500, 32'h600, 32'he00, 32'h700};
   mcim_router dut (.ref_clk_in, .rst_in, .mode_in, .cu_req_in, .cu_ready_out, .ch_req_out, .ch_ready_in,
      .launch_start_in, .num_groups_x_in, .num_groups_y_in, .cu_done_in, .launch_valid_out, .launch_cu_out,
      .launch_group_x_out, .launch_group_y_out, .workgroup_launch_index_out, .retire_index_out, .launch_busy_out);
   mcim_ch_model chm (.ref_clk_in, .rst_in, .pace_in(pace), .ch_ready_out(ch_ready_in));
   always #5 ref_clk_in = ~ref_clk_in;
   // hang guard, far above the hundred or so cycles the tests need
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // inputs move 1 ns after the edge so no race with the sampling edge
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : tick
   // units 0..n-1 fire together, unit u must land in slot u
   task automatic issue(int n);
      for (int u = 0; u < n; u++) cu_req_in[u] = '{1'b1, 1'b0, adr[u], 6'(u)};
      #1;
      for (int u = 0; u < n; u++) chk("grant", 32'(cu_ready_out[u]), 32'h1);
      tick(1);
      cu_req_in = '0;
      for (int u = 0; u < n; u++) begin
         chk("slot addr", ch_req_out[u].addr, adr[u]);
         chk("slot unit", {ch_req_out[u].valid, 27'h0, ch_req_out[u].src_cu}, 32'h80000000 + 32'(u));
      end
      tick(3);
   endtask : issue
   task automatic t_pow2();
      mode_in = mcim_pkg::MCIM_MODE_8;
      for (int u = 0; u < 8; u++) adr[u] = 32'h3000 + 32'(u) * 32'h100;
      issue(8);
      mode_in = mcim_pkg::MCIM_MODE_4;
      for (int u = 0; u < 4; u++) adr[u] = 32'h400 + 32'(u) * 32'h100;
      issue(4);
      $display("pow2 test done");
   endtask : t_pow2
   // two units hit one channel and bank while the channel stalls
   task automatic t_stall();
      int k;
      mode_in = mcim_pkg::MCIM_MODE_8;
      pace = 2'h1;
      cu_req_in[0] = '{1'b1, 1'b0, 32'h0, 6'h0};
      cu_req_in[1] = '{1'b1, 1'b1, 32'h10000, 6'h1};
      cu_req_in[2] = '{1'b1, 1'b0, 32'h100, 6'h2};
      #1;
      chk("conflict grants", {29'h0, cu_ready_out[2:0]}, 32'h5);
      tick(1);
      cu_req_in[0] = '0;
      cu_req_in[2] = '0;
      tick(2);
      chk("held slot", ch_req_out[0].addr, 32'h0);
      pace = 2'h2;
      #1; // let the new ready reach the grant before it is read
      for (k = 0; k < 10 && !cu_ready_out[1]; k++) tick(1);
      chk("late grant", 32'(k < 10), 32'h1);
      tick(1);
      cu_req_in = '0;
      chk("second slot", ch_req_out[0].addr, 32'h10000);
      chk("second slot kind", 32'({ch_req_out[0].valid, ch_req_out[0].write, ch_req_out[0].wave_id}), 32'h000000c1);
      pace = 2'h0;
      tick(4);
      $display("stall test done");
   endtask : t_stall
   task automatic wait_launch(int i, int cu);
      for (int k = 0; k < 20 && !launch_valid_out; k++) tick(1);
      chk("launch unit", 32'(launch_cu_out), 32'(cu));
      chk("launch x", 32'(launch_group_x_out), 32'(i % 7));
      chk("launch y", 32'(launch_group_y_out), 32'(i / 7));
      chk("launch index", 32'(workgroup_launch_index_out), 32'(i));
      tick(1);
   endtask : wait_launch
   task automatic t_launch();
      launch_start_in = 1'b1;
      tick(1);
      launch_start_in = 1'b0;
      for (int i = 0; i < 12; i++) wait_launch(i, i);
      cu_done_in = 12'h001;
      tick(1);
      cu_done_in = 12'h000;
      wait_launch(12, 0);
      cu_done_in = 12'h004;
      tick(1);
      cu_done_in = 12'h000;
      tick(4);
      chk("retire held", 32'(retire_index_out), 32'h1);
      repeat (3) begin
         cu_done_in = 12'hfff;
         tick(1);
         cu_done_in = 12'h000;
         tick(20);
      end
      chk("retired all", {15'h0, launch_busy_out, retire_index_out}, 32'he);
      $display("launch test done");
   endtask : t_launch
   initial begin
      tick(5);
      rst_in = 1'b0;
      chk("l2 lines", 32'(mcim_pkg::L2_LINES), 32'h00000400);
      issue(12);
      $display("twelve channel test done");
      t_pow2();
      t_stall();
      t_launch();
      end_of_test();
   end
endmodule : tb_mcim_router
